// *** design/cpwm_defs.vh ***
// Register offsets, field positions, reset values and encodings of the unit.
`ifndef CPWM_DEFS_VH
`define CPWM_DEFS_VH

// ==========================================================================
// Register offsets on the 8-bit register port
// ==========================================================================
`define CPWM_ADDR_W           4
`define CPWM_OFS_UNIT_CONTROL 4'h0
`define CPWM_OFS_CMP_LOW      4'h1
`define CPWM_OFS_CMP_HIGH     4'h2
`define CPWM_OFS_T1_LOW       4'h3
`define CPWM_OFS_T1_HIGH      4'h4
`define CPWM_OFS_T1_CONTROL   4'h5
`define CPWM_OFS_PERIOD       4'h6
`define CPWM_OFS_T2_CONTROL   4'h7
`define CPWM_OFS_T2_COUNT     4'h8
`define CPWM_OFS_INT_FLAGS    4'h9
`define CPWM_OFS_INT_ENABLE   4'ha
`define CPWM_OFS_PORT_C_DIR   4'hb

// ==========================================================================
// Field positions
// ==========================================================================
`define CPWM_MODE_HI          3
`define CPWM_MODE_LO          0
`define CPWM_DUTY_HI          5
`define CPWM_DUTY_LO          4
`define CPWM_FLAG_UNIT        5
`define CPWM_FLAG_T1_OVF      0
`define CPWM_T1_ON            0
`define CPWM_T2_ON            2
`define CPWM_T2_PRE_HI        1
`define CPWM_T2_PRE_LO        0
`define CPWM_PIN_DIR_BIT      5

// ==========================================================================
// Reset values
// ==========================================================================
`define CPWM_RST_ZERO         8'h00
`define CPWM_RST_DIR          8'h3f
`define CPWM_RST_PERIOD       8'hff

// ==========================================================================
// Mode select encodings
// ==========================================================================
`define CPWM_MODE_OFF         4'h0
`define CPWM_MODE_TOGGLE      4'h2
`define CPWM_MODE_SET         4'h8
`define CPWM_MODE_CLEAR       4'h9
`define CPWM_MODE_SOFT_INT    4'ha
`define CPWM_MODE_SPECIAL     4'hb
`define CPWM_PWM_PREFIX       2'h3

// ==========================================================================
// Timing counts
// ==========================================================================
`define CPWM_OSC_PER_CYCLE    4
`define CPWM_PHASE_LAST       2'h3
`define CPWM_PRE_1            2'h0
`define CPWM_PRE_4            2'h1
`define CPWM_PRE_4_LAST       4'h3
`define CPWM_PRE_16_LAST      4'hf

`endif

// *** design/cpwm_unit.v ***
// Compare and basic PWM unit with its timers and register port.
//
// Contract
// - Compare mode always matches the 16-bit compare pair with timer one.
// - The mode field picks toggle, set, clear, special event or interrupt.
// - Every compare mode sets the unit interrupt flag on a match.
// - Special event zeroes timer one, sets no overflow, starts conversion.
// - Zero written to unit control forces compare latch low, not port latch.
// - Mode 1010 only raises the interrupt flag and leaves the pin alone.
// - Mode 1011 resets timer one, starts conversion if enabled, frees pin.
// - Special event asserts at match; timer one clears at its next tick.
// - If the match vanishes before that tick, timer one is not cleared.
// - PWM mode produces up to 10-bit resolution pulses on the pin.
// - Writing zero to unit control releases the output pin.
// - PWM period is (period+1) times four clocks times timer-two prescale.
// - After timer two equals period: clear it, set pin unless the new duty is zero, reload duty buffer.
// - The timer-two postscaler has no effect on the PWM period.
// - Duty value is duty low byte over the two duty bits of control.
// - Time base is timer two plus two low bits from phase or prescaler.
// - Pin clears when the 10-bit time base equals the buffered duty.
`timescale 1ns/1ps
`include "cpwm_defs.vh"

module cpwm_unit
(
  input  wire       mclk_in,          // System clock, 200 MHz.
  input  wire       nrst_in,          // Asynchronous reset, active low.
  input  wire [3:0] addr_in,          // Register address.
  input  wire [7:0] wdata_in,         // Register write data.
  input  wire       wr_in,            // Write strobe, one cycle.
  input  wire       rd_in,            // Read strobe, one cycle.
  input  wire       timer_one_tick_in, // Timer-one clock tick, one cycle.
  input  wire       adc_enable_in,    // Converter is switched on.
  output reg  [7:0] rdata_out,        // Read data, cycle after the strobe.
  output reg        unit_pin_out,     // Level offered to the unit output pin.
  output wire       unit_pin_oe_out,  // Unit drives the pin.
  output wire       special_event_out, // Special event trigger, at match.
  output wire       adc_start_out     // Conversion start request pulse.
);

  // ========================================================================
  // Reset release
  // ========================================================================
  reg        rst_meta;
  reg        rst_n;

  // Release the reset through two flip-flops, assert it at once.
  always @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ========================================================================
  // Register storage
  // ========================================================================
  reg  [7:0]  unit_control;
  reg  [7:0]  compare_value_low;
  reg  [7:0]  compare_value_high;
  reg  [15:0] timer_one_count;
  reg  [7:0]  timer_one_control;
  reg  [7:0]  period_register;
  reg  [7:0]  timer_two_control;
  reg  [7:0]  timer_two_count;
  reg  [7:0]  peripheral_interrupt_enable;
  reg  [7:0]  port_c_direction;
  reg         unit_interrupt_flag;
  reg         timer_one_overflow_flag;
  reg         compare_latch;
  reg         match_seen;
  reg  [1:0]  phase;
  reg  [3:0]  prescale;
  reg  [9:0]  duty_buffer;

  wire [3:0]  mode_select_field = unit_control[`CPWM_MODE_HI:`CPWM_MODE_LO];
  wire [1:0]  duty_low_bits     = unit_control[`CPWM_DUTY_HI:`CPWM_DUTY_LO];
  wire [15:0] compare_value_pair = {compare_value_high, compare_value_low};

  // Decodes whether a mode code drives the compare latch onto the pin.
  function is_pin_mode;
    input [3:0] m;
    begin
      is_pin_mode = (m == `CPWM_MODE_TOGGLE) || (m == `CPWM_MODE_SET) ||
                    (m == `CPWM_MODE_CLEAR);
    end
  endfunction

  // Decodes whether a mode code is any compare mode.
  function is_compare_mode;
    input [3:0] m;
    begin
      is_compare_mode = is_pin_mode(m) || (m == `CPWM_MODE_SOFT_INT) ||
                        (m == `CPWM_MODE_SPECIAL);
    end
  endfunction

  wire pwm_mode     = (mode_select_field[3:2] == `CPWM_PWM_PREFIX);
  wire compare_mode = is_compare_mode(mode_select_field);
  wire special_mode = (mode_select_field == `CPWM_MODE_SPECIAL);

  // ========================================================================
  // Compare engine
  // ========================================================================
  wire match       = compare_mode &&
                     (compare_value_pair == timer_one_count);
  wire match_event = match && !match_seen;

  // The trigger follows the live match, so it shows in the match cycle.
  assign special_event_out = special_mode && match;
  assign adc_start_out     = special_mode && match_event &&
                             adc_enable_in;

  // The unit holds the pin only in pin-driving compare modes and in PWM,
  // and only when software has made the pin an output.
  assign unit_pin_oe_out = (is_pin_mode(mode_select_field) || pwm_mode) &&
                           !port_c_direction[`CPWM_PIN_DIR_BIT];

  wire wr_ctrl = wr_in && (addr_in == `CPWM_OFS_UNIT_CONTROL);

  // Remembers the match so a held match acts only once.
  always @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
      match_seen <= 1'b0;
    else
      match_seen <= match;
  end

  // Compare output latch: a set or clear mode write presets it, a match acts on it.
  always @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
      compare_latch <= 1'b0;
    else if (wr_ctrl && (wdata_in == `CPWM_RST_ZERO))
      compare_latch <= 1'b0;
    else if (wr_ctrl &&
             (wdata_in[3:0] == `CPWM_MODE_SET))
      compare_latch <= 1'b0;
    else if (wr_ctrl &&
             (wdata_in[3:0] == `CPWM_MODE_CLEAR))
      compare_latch <= 1'b1;
    else if (match_event)
    begin
      case (mode_select_field)
        `CPWM_MODE_TOGGLE: compare_latch <= !compare_latch;
        `CPWM_MODE_SET:    compare_latch <= 1'b1;
        `CPWM_MODE_CLEAR:  compare_latch <= 1'b0;
        default:           compare_latch <= compare_latch;
      endcase
    end
  end

  // ========================================================================
  // Timer one
  // ========================================================================
  wire t1_run   = timer_one_tick_in && timer_one_control[`CPWM_T1_ON];
  wire t1_reset = t1_run && special_mode && match;
  wire t1_wrap  = t1_run && !t1_reset && (timer_one_count == 16'hffff);

  // Counts ticks; the special event clears it on the next tick, but only
  // if the match still stands then.
  always @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
      timer_one_count <= 16'h0000;
    else if (wr_in && (addr_in == `CPWM_OFS_T1_LOW))
      timer_one_count <= {timer_one_count[15:8], wdata_in};
    else if (wr_in && (addr_in == `CPWM_OFS_T1_HIGH))
      timer_one_count <= {wdata_in, timer_one_count[7:0]};
    else if (t1_reset)
      timer_one_count <= 16'h0000;
    else if (t1_run)
      timer_one_count <= timer_one_count + 16'h0001;
  end

  // ========================================================================
  // Timer two and the PWM time base
  // ========================================================================
  wire [1:0] pre_sel  = timer_two_control[`CPWM_T2_PRE_HI:`CPWM_T2_PRE_LO];
  wire       t2_on    = timer_two_control[`CPWM_T2_ON];
  wire       cycle_end = (phase == `CPWM_PHASE_LAST);
  wire       pre_done = (pre_sel == `CPWM_PRE_1) ? 1'b1 :
                        (pre_sel == `CPWM_PRE_4) ?
                        (prescale == `CPWM_PRE_4_LAST) :
                        (prescale == `CPWM_PRE_16_LAST);
  wire       t2_inc   = t2_on && cycle_end && pre_done;
  wire       t2_roll  = t2_inc &&
                        (timer_two_count == period_register);
  wire       t2_wr    = wr_in && (addr_in == `CPWM_OFS_T2_COUNT);
  wire [1:0] tb_low   = (pre_sel == `CPWM_PRE_1) ? phase :
                        (pre_sel == `CPWM_PRE_4) ? prescale[1:0] :
                        prescale[3:2];
  wire [9:0] time_base = {timer_two_count, tb_low};
  wire [9:0] duty_next = {compare_value_low, duty_low_bits};

  // The time base moves every clock at 1:1, every cycle at 1:4, every four cycles at 1:16.
  wire       tb_step  = (pre_sel == `CPWM_PRE_1) ? 1'b1 :
                        (pre_sel == `CPWM_PRE_4) ? cycle_end :
                        (cycle_end &&
                         (prescale[1:0] == `CPWM_PHASE_LAST));
  wire [9:0] tb_next  = time_base + 10'h001;

  // Four clocks make one instruction cycle; the phase runs free.
  always @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
      phase <= 2'h0;
    else
      phase <= phase + 2'h1;
  end

  // Prescaler counts instruction cycles; the postscaler bits are ignored.
  always @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
      prescale <= 4'h0;
    else if (t2_wr || !t2_on || t2_inc)
      prescale <= 4'h0;
    else if (cycle_end)
      prescale <= prescale + 4'h1;
  end

  // Timer two counts up to the period value, then starts again at zero.
  always @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
      timer_two_count <= 8'h00;
    else if (t2_wr)
      timer_two_count <= wdata_in;
    else if (t2_roll)
      timer_two_count <= 8'h00;
    else if (t2_inc)
      timer_two_count <= timer_two_count + 8'h01;
  end

  // Duty buffer reloads only at a period boundary, so no glitches.
  always @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
      duty_buffer <= 10'h000;
    else if (t2_roll)
      duty_buffer <= duty_next;
  end

  // Pin level: PWM sets at period start unless the duty is zero, and clears at the duty match.
  // The clear looks one step ahead, so the pin falls on the very edge at
  // which the time base reaches the duty; a registered late match would
  // stretch every pulse by one clock.
  always @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
      unit_pin_out <= 1'b0;
    else if (pwm_mode)
    begin
      if (t2_roll)
        unit_pin_out <= (duty_next != 10'h000);
      else if (tb_step && (tb_next == duty_buffer))
        unit_pin_out <= 1'b0;
    end
    else
      unit_pin_out <= compare_latch;
  end

  // ========================================================================
  // Software registers
  // ========================================================================
  // Plain stored registers; a reset zeroes unit control.
  always @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      unit_control                <= `CPWM_RST_ZERO;
      compare_value_low           <= `CPWM_RST_ZERO;
      compare_value_high          <= `CPWM_RST_ZERO;
      timer_one_control           <= `CPWM_RST_ZERO;
      period_register             <= `CPWM_RST_PERIOD;
      timer_two_control           <= `CPWM_RST_ZERO;
      peripheral_interrupt_enable <= `CPWM_RST_ZERO;
      port_c_direction            <= `CPWM_RST_DIR;
    end
    else
    begin
      if (wr_in)
      begin
      case (addr_in)
        `CPWM_OFS_UNIT_CONTROL: unit_control <= wdata_in;
        `CPWM_OFS_CMP_LOW:      compare_value_low <= wdata_in;
        `CPWM_OFS_CMP_HIGH:
        begin
          if (!pwm_mode)
            compare_value_high <= wdata_in;
        end
        `CPWM_OFS_T1_CONTROL:   timer_one_control <= wdata_in;
        `CPWM_OFS_PERIOD:       period_register <= wdata_in;
        `CPWM_OFS_T2_CONTROL:   timer_two_control <= wdata_in;
        `CPWM_OFS_INT_ENABLE:   peripheral_interrupt_enable <= wdata_in;
        `CPWM_OFS_PORT_C_DIR:   port_c_direction <= wdata_in & 8'h3f;
        default:                unit_control <= unit_control;
      endcase
      end
      // The duty copy must not be lost to a write in the same cycle.
      if (pwm_mode && t2_roll)
        compare_value_high <= compare_value_low;
    end
  end

  // Flags: a hardware set wins over a software clear in the same cycle.
  wire wr_flags = wr_in && (addr_in == `CPWM_OFS_INT_FLAGS);
  always @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      unit_interrupt_flag     <= 1'b0;
      timer_one_overflow_flag <= 1'b0;
    end
    else
    begin
      unit_interrupt_flag <= match_event ||
        (wr_flags ? wdata_in[`CPWM_FLAG_UNIT] : unit_interrupt_flag);
      timer_one_overflow_flag <= t1_wrap ||
        (wr_flags ? wdata_in[`CPWM_FLAG_T1_OVF] : timer_one_overflow_flag);
    end
  end

  // Read data, registered; unmapped addresses read zero.
  always @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
      rdata_out <= 8'h00;
    else if (rd_in)
    begin
      case (addr_in)
        `CPWM_OFS_UNIT_CONTROL: rdata_out <= unit_control;
        `CPWM_OFS_CMP_LOW:      rdata_out <= compare_value_low;
        `CPWM_OFS_CMP_HIGH:     rdata_out <= compare_value_high;
        `CPWM_OFS_T1_LOW:       rdata_out <= timer_one_count[7:0];
        `CPWM_OFS_T1_HIGH:      rdata_out <= timer_one_count[15:8];
        `CPWM_OFS_T1_CONTROL:   rdata_out <= timer_one_control;
        `CPWM_OFS_PERIOD:       rdata_out <= period_register;
        `CPWM_OFS_T2_CONTROL:   rdata_out <= timer_two_control;
        `CPWM_OFS_T2_COUNT:     rdata_out <= timer_two_count;
        `CPWM_OFS_INT_FLAGS:
          rdata_out <= {2'h0, unit_interrupt_flag, 4'h0,
                        timer_one_overflow_flag};
        `CPWM_OFS_INT_ENABLE:   rdata_out <= peripheral_interrupt_enable;
        `CPWM_OFS_PORT_C_DIR:   rdata_out <= port_c_direction;
        default:                rdata_out <= 8'h00;
      endcase
    end
  end

endmodule // cpwm_unit

// *** test/cpwm_far_side.sv ***
// Far-side model: pin load with pull-down, converter and timer-one clock.
`timescale 1ns/1ps
module cpwm_far_side
(
  input  wire       mclk_in,       // System clock.
  input  wire       tick_en_in,    // Lets timer-one ticks through.
  input  wire       pin_in,        // Level offered by the unit.
  input  wire       pin_oe_in,     // Unit drives the pin.
  input  wire       adc_start_in,  // Conversion start pulse.
  output wire       tick_out,      // Timer-one tick, one cycle.
  output wire       pin_wire_out,  // Level seen on the wire.
  output reg  [7:0] adc_count_out  // Conversions started so far.
);
  reg [1:0] div = 2'h0;

  // ==========================================================================
  // Timer-one clock
  // ==========================================================================
  // Ticks stay synchronous to the system clock, one in four cycles.
  always @(posedge mclk_in)
  begin
    div <= div + 2'h1;
  end
  assign tick_out = tick_en_in & (div == 2'h3);

  // ==========================================================================
  // Pin and converter
  // ==========================================================================
  // A released pin is pulled low by the load, so stale levels never show.
  assign pin_wire_out = pin_oe_in ? pin_in : 1'b0;
  // The converter counts every start request it sees.
  initial adc_count_out = 8'h00;
  always @(posedge mclk_in)
  begin
    if (adc_start_in)
      adc_count_out <= adc_count_out + 8'h01;
  end
endmodule // cpwm_far_side

// *** test/cpwm_unit_asserts.sv ***
// Concurrent checks on the ports of the compare and PWM unit.
`timescale 1ns/1ps
`include "cpwm_defs.vh"
module cpwm_unit_asserts
(
  input wire       mclk_in,           // System clock.
  input wire       nrst_in,           // Reset, active low.
  input wire [3:0] addr_in,           // Register address.
  input wire [7:0] wdata_in,          // Write data.
  input wire       wr_in,             // Write strobe.
  input wire       adc_enable_in,     // Converter enabled.
  input wire       unit_pin_out,      // Pin level.
  input wire       unit_pin_oe_out,   // Pin drive enable.
  input wire       special_event_out, // Special event.
  input wire       adc_start_out      // Conversion start.
);
  wire ctl_wr = wr_in && (addr_in == `CPWM_OFS_UNIT_CONTROL);

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);

  // ==========================================================================
  // Event and pin checks
  // ==========================================================================
  adc_cause_a: assert property (
    adc_start_out |-> special_event_out && adc_enable_in)
    else $error("conversion start without enabled event");
  adc_pulse_a: assert property (adc_start_out |=> !adc_start_out)
    else $error("conversion start longer than one cycle");
  adc_first_a: assert property (
    $rose(special_event_out) && adc_enable_in |-> adc_start_out)
    else $error("conversion start late at match");
  event_no_pin_a: assert property (
    special_event_out |-> !unit_pin_oe_out)
    else $error("pin driven in special event mode");
  clear_release_a: assert property (
    ctl_wr && wdata_in == 8'h00 |=> !unit_pin_oe_out)
    else $error("pin kept after control cleared");
  latch_low_a: assert property (
    ctl_wr && wdata_in == 8'h00 |-> ##[1:2] !unit_pin_out)
    else $error("compare latch not forced low");
  reset_release_a: assert property (
    $rose(nrst_in) |-> !unit_pin_oe_out && !special_event_out)
    else $error("unit active out of reset");
  quiet_mode_a: assert property (
    ctl_wr && wdata_in[3:1] == 3'b101 |=> !unit_pin_oe_out)
    else $error("pin driven in interrupt or event mode");
endmodule // cpwm_unit_asserts

bind cpwm_unit cpwm_unit_asserts u_chk
(
  .mclk_in           (mclk_in),
  .nrst_in           (nrst_in),
  .addr_in           (addr_in),
  .wdata_in          (wdata_in),
  .wr_in             (wr_in),
  .adc_enable_in     (adc_enable_in),
  .unit_pin_out      (unit_pin_out),
  .unit_pin_oe_out   (unit_pin_oe_out),
  .special_event_out (special_event_out),
  .adc_start_out     (adc_start_out)
);

// *** test/cpwm_unit_tb.sv ***
// Self-checking bench for the compare and PWM unit.
`timescale 1ns/1ps
`include "cpwm_defs.vh"
`define CHK(n, e, g) \
  begin \
    n_checks = n_checks + 1; \
    if ((g) !== (e)) \
    begin \
      bad_count = bad_count + 1; \
      $display("wrong value %s exp %0h got %0h", n, e, g); \
    end \
  end
module cpwm_unit_tb;
  localparam [19:0] MODES = 20'h1a298;
  localparam [4:0]  PINS  = 5'b00101;
  localparam [4:0]  OES   = 5'b00111;
  localparam [4:0]  FLGS  = 5'b01111;
  reg        mclk_in   = 1'b0;
  reg        nrst_in   = 1'b0;
  reg  [3:0] addr_in   = 4'h0;
  reg  [7:0] wdata_in  = 8'h00;
  reg        wr_in     = 1'b0;
  reg        rd_in     = 1'b0;
  reg        tick_en   = 1'b0;
  reg        adc_en    = 1'b0;
  wire       tick;
  wire       pin;
  wire       oe;
  wire       sev;
  wire       adc_st;
  wire       pin_wire;
  wire [7:0] rdata;
  wire [7:0] n_adc;
  reg  [7:0] rv;
  integer    bad_count = 0;
  integer    n_checks  = 0;
  integer    i;
  integer    hi;
  integer    per;

  cpwm_unit u_dut
  (
    .mclk_in           (mclk_in),
    .nrst_in           (nrst_in),
    .addr_in           (addr_in),
    .wdata_in          (wdata_in),
    .wr_in             (wr_in),
    .rd_in             (rd_in),
    .timer_one_tick_in (tick),
    .adc_enable_in     (adc_en),
    .rdata_out         (rdata),
    .unit_pin_out      (pin),
    .unit_pin_oe_out   (oe),
    .special_event_out (sev),
    .adc_start_out     (adc_st)
  );

  cpwm_far_side u_far
  (
    .mclk_in       (mclk_in),
    .tick_en_in    (tick_en),
    .pin_in        (pin),
    .pin_oe_in     (oe),
    .adc_start_in  (adc_st),
    .tick_out      (tick),
    .pin_wire_out  (pin_wire),
    .adc_count_out (n_adc)
  );

  // ==========================================================================
  // Clock, bus tasks and verdict
  // ==========================================================================
  // The clock runs at 200 MHz.
  initial forever #2.5 mclk_in = ~mclk_in;

  // One-cycle write strobe beside address and data.
  task wr(input [3:0] a, input [7:0] d);
  begin
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in    <= 1'b0;
  end
  endtask

  // One-cycle read strobe; the data stand in the following cycle.
  task rd(input [3:0] a);
  begin
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in   <= 1'b0;
    #1 rv = rdata;
  end
  endtask

  // Measures high time and period of one pulse on the wire.
  task meas(output integer h, output integer p);
    integer k;
  begin
    h = 0;
    p = 0;
    k = 0;
    while (pin_wire !== 1'b1 && k < 300)
    begin
      @(posedge mclk_in) #1 k = k + 1;
    end
    while (pin_wire === 1'b1 && h < 300)
    begin
      @(posedge mclk_in) #1 h = h + 1;
    end
    p = h;
    while (pin_wire === 1'b0 && p < 600)
    begin
      @(posedge mclk_in) #1 p = p + 1;
    end
  end
  endtask

  // Prints the counts and the verdict, then stops.
  task wrap_up;
  begin
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask

  // A hang counts as a mismatch.
  initial
  begin
    #200000;
    bad_count = bad_count + 1;
    wrap_up;
  end

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial
  begin
    repeat (8) @(posedge mclk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    rd(`CPWM_OFS_UNIT_CONTROL);
    `CHK("control reset", 8'h00, rv)
    rd(`CPWM_OFS_PORT_C_DIR);
    `CHK("direction reset", 8'h3f, rv)
    wr(`CPWM_OFS_UNIT_CONTROL, 8'h30);
    rd(`CPWM_OFS_UNIT_CONTROL);
    `CHK("duty bits", 8'h30, rv)
    wr(`CPWM_OFS_PORT_C_DIR, 8'h1f);
    wr(`CPWM_OFS_T1_CONTROL, 8'h01);
    // Mode codes but special event: reserved, interrupt, toggle, clear, set.
    for (i = 0; i < 5; i = i + 1)
    begin
      wr(`CPWM_OFS_UNIT_CONTROL, 8'h00);
      wr(`CPWM_OFS_INT_FLAGS, 8'h00);
      wr(`CPWM_OFS_T1_LOW, 8'h00);
      wr(`CPWM_OFS_T1_HIGH, 8'h00);
      wr(`CPWM_OFS_CMP_LOW, 8'h03);
      wr(`CPWM_OFS_CMP_HIGH, 8'h00);
      wr(`CPWM_OFS_UNIT_CONTROL, {4'h0, MODES[19-4*i -: 4]});
      tick_en <= 1'b1;
      repeat (30) @(posedge mclk_in);
      tick_en <= 1'b0;
      #1 `CHK("pin enable", OES[4-i], oe)
      if (OES[4-i])
        `CHK("pin level", PINS[4-i], pin_wire)
      rd(`CPWM_OFS_INT_FLAGS);
      `CHK("match flag", FLGS[4-i], rv[5])
    end
    wr(`CPWM_OFS_UNIT_CONTROL, 8'h00);
    repeat (2) @(posedge mclk_in);
    #1 `CHK("latch low", 1'b0, pin)
    `CHK("released", 1'b0, oe)
    // Special event: match kept, match removed, converter off.
    for (i = 0; i < 3; i = i + 1)
    begin
      adc_en <= (i != 2);
      wr(`CPWM_OFS_UNIT_CONTROL, 8'h00);
      wr(`CPWM_OFS_INT_FLAGS, 8'h00);
      wr(`CPWM_OFS_T1_LOW, 8'h04);
      wr(`CPWM_OFS_CMP_LOW, 8'h04);
      wr(`CPWM_OFS_UNIT_CONTROL, 8'h0b);
      #1 `CHK("event", 1'b1, sev)
      if (i == 1)
        wr(`CPWM_OFS_CMP_LOW, 8'h06);
      tick_en <= 1'b1;
      repeat (4) @(posedge mclk_in);
      tick_en <= 1'b0;
      rd(`CPWM_OFS_T1_LOW);
      `CHK("timer one", (i == 1) ? 8'h05 : 8'h00, rv)
      rd(`CPWM_OFS_INT_FLAGS);
      `CHK("flags", 8'h20, rv)
    end
    `CHK("conversions", 8'h02, n_adc)
    // PWM: period 3, duty 9, postscale bits set, prescale 1, then 16, then 4.
    wr(`CPWM_OFS_PERIOD, 8'h03);
    wr(`CPWM_OFS_CMP_LOW, 8'h02);
    wr(`CPWM_OFS_UNIT_CONTROL, 8'h1c);
    wr(`CPWM_OFS_T2_CONTROL, 8'h7c);
    meas(hi, per);
    `CHK("high time", 9, hi)
    `CHK("period", 16, per)
    wr(`CPWM_OFS_CMP_HIGH, 8'h55);
    rd(`CPWM_OFS_CMP_HIGH);
    `CHK("duty buffer", 8'h02, rv)
    // Prescale 16: the first pulse after the switch may be cut short.
    wr(`CPWM_OFS_T2_CONTROL, 8'h06);
    meas(hi, per);
    meas(hi, per);
    `CHK("high time x16", 144, hi)
    `CHK("period x16", 256, per)
    wr(`CPWM_OFS_T2_CONTROL, 8'h05);
    meas(hi, per);
    meas(hi, per);
    `CHK("high time x4", 36, hi)
    `CHK("period x4", 64, per)
    wr(`CPWM_OFS_CMP_LOW, 8'h00);
    wr(`CPWM_OFS_UNIT_CONTROL, 8'h0c);
    repeat (80) @(posedge mclk_in);
    hi = 0;
    repeat (130)
    begin
      @(posedge mclk_in) #1 hi = hi + (pin_wire !== 1'b0);
    end
    `CHK("zero duty", 0, hi)
    wrap_up;
  end
endmodule // cpwm_unit_tb
